/* File: rtl/core_speed_clock_control.sv */
/*
 * core clock source select, divider, oscillator shutdown and interrupt
 * speed switching, with an avalon-mm register slave.
 * assumes the core clock is used as a clock enable on sys_clk_in, and
 * the core holds speed_valid_in until speed_ready_out.
 */
// Added by the designer: the address map and the Avalon-MM interface to the registers.
module core_speed_clock_control (
    input  wire logic                  sys_clk_in,
    input  wire logic                  rst_in,
    input  wire logic                  ce_in,
    input  wire logic                  main_osc_clock_in,
    input  wire logic                  realtime_osc_clock_in,
    input  wire logic                  speed_valid_in,
    input  wire speed_clk_pkg::speed_t speed_word_in,
    input  wire logic                  irq_enter_in,
    input  wire logic                  irq_return_in,
    input  wire logic [3:0]            avs_address_in,
    input  wire logic                  avs_read_in,
    input  wire logic                  avs_write_in,
    input  wire logic [3:0]            avs_byteenable_in,
    input  wire logic [31:0]           avs_writedata_in,
    output logic [31:0]                avs_readdata_out,
    output logic                       avs_waitrequest_out,
    output logic                       speed_ready_out,
    output logic                       core_clk_out,
    output logic                       timer_clk_en_out,
    output logic                       main_osc_en_out,
    output logic                       pll_en_out,
    output logic                       pll_locked_out
);
    speed_clk_pkg::speed_t   cur_q, cur_d, pend_q, pend_d, saved_q, saved_d;
    speed_clk_pkg::speed_t   isr_word_q, isr_word_d;
    speed_clk_pkg::pll_cfg_t pll_cfg_q, pll_cfg_d;
    logic        pend_v_q, pend_v_d, in_isr_q, in_isr_d, auto_q, auto_d;
    logic [6:0]  div_cnt_q, div_cnt_d;
    logic        core_clk_q, core_clk_d, ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic        main_raw, main_tick, rt_tick, pll_tick, src_tick, core_tick;
    logic        enter_acc, ret_acc, speed_acc, req;
    logic [31:0] ctrl_word, pll_word, wr_word;

    function automatic logic [31:0] merge(input logic [31:0] old_w,
                                          input logic [31:0] new_w,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old_w;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) r[i*8 +: 8] = new_w[i*8 +: 8];
        end
        return r;
    endfunction

    osc_edge_tick u_main_tick (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .ce_in      (ce_in),
        .osc_in     (main_osc_clock_in),
        .tick_out   (main_raw)
    );

    osc_edge_tick u_rt_tick (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .ce_in      (ce_in),
        .osc_in     (realtime_osc_clock_in),
        .tick_out   (rt_tick)
    );

    // multiplier references the main oscillator
    pll_tick_gen u_pll (
        .sys_clk_in  (sys_clk_in),
        .rst_in      (rst_in),
        .ce_in       (ce_in),
        .enable_in   (pll_en_out),
        .ref_tick_in (main_tick),
        .cfg_in      (pll_cfg_q),
        .tick_out    (pll_tick),
        .locked_out  (pll_locked_out)
    );

    assign main_osc_en_out = !cur_q.osc_off;
    assign pll_en_out      = !cur_q.pll_off;
    assign main_tick       = main_raw & main_osc_en_out;

    always_comb begin
        case (cur_q.src)
            speed_clk_pkg::SRC_RT:  src_tick = rt_tick;
            speed_clk_pkg::SRC_PLL: src_tick = pll_tick;
            default:                src_tick = main_tick;
        endcase
    end

    // never two high cycles in a row, so no runt or merged pulse
    assign core_tick = src_tick && (div_cnt_q == cur_q.div_m1)
                       && !core_clk_q;
    assign enter_acc = irq_enter_in && auto_q && !in_isr_q;
    assign ret_acc   = irq_return_in && in_isr_q && !enter_acc;
    assign speed_acc = speed_valid_in && !pend_v_q && !enter_acc && !ret_acc;
    assign speed_ready_out  = !pend_v_q && !enter_acc && !ret_acc;
    assign timer_clk_en_out = src_tick;
    assign core_clk_out     = core_clk_q;
    assign req              = avs_read_in || avs_write_in;
    assign avs_waitrequest_out = req && !ack_q;
    assign avs_readdata_out = rdata_q;
    assign ctrl_word = {15'h0000, auto_q, 5'h00, isr_word_q};
    assign pll_word  = {12'h000, pll_cfg_q.postdiv_m1, pll_cfg_q.mult,
                        4'h0, pll_cfg_q.prediv_m1};
    assign wr_word   = merge(avs_address_in == speed_clk_pkg::CTRL_OFS
                             ? ctrl_word : pll_word,
                             avs_writedata_in, avs_byteenable_in);

    always_comb begin
        cur_d      = cur_q;
        pend_d     = pend_q;
        pend_v_d   = pend_v_q;
        saved_d    = saved_q;
        in_isr_d   = in_isr_q;
        isr_word_d = isr_word_q;
        auto_d     = auto_q;
        pll_cfg_d  = pll_cfg_q;
        div_cnt_d  = div_cnt_q;
        rdata_d    = rdata_q;
        core_clk_d = core_tick;
        ack_d      = req && !ack_q;
        if (core_tick) begin
            div_cnt_d = 7'h00;
        end else if (src_tick && div_cnt_q != cur_q.div_m1) begin
            div_cnt_d = div_cnt_q + 7'h01;
        end
        // old divisor runs the cycle out, counter restarts clean
        if (core_tick && pend_v_q) begin
            cur_d     = pend_q;
            pend_v_d  = 1'b0;
            div_cnt_d = 7'h00;
        end
        // a new event the same cycle re-arms pending: set beats clear
        if (enter_acc) begin
            saved_d  = pend_v_q ? pend_q : cur_q;
            pend_d   = isr_word_q;
            pend_v_d = 1'b1;
            in_isr_d = 1'b1;
        end else if (ret_acc) begin
            pend_d   = saved_q;
            pend_v_d = 1'b1;
            in_isr_d = 1'b0;
        end else if (speed_acc) begin
            pend_d   = speed_word_in;
            pend_v_d = 1'b1;
        end
        if (avs_read_in && !ack_q) begin
            if (avs_address_in == speed_clk_pkg::CTRL_OFS) begin
                rdata_d = ctrl_word;
            end else if (avs_address_in == speed_clk_pkg::PLLCFG_OFS) begin
                rdata_d = pll_word;
            end else if (avs_address_in == speed_clk_pkg::STATUS_OFS) begin
                rdata_d = 32'h0;
                rdata_d[speed_clk_pkg::SPEED_W-1:0] = cur_q;
                rdata_d[speed_clk_pkg::STAT_LOCK_BIT] = pll_locked_out;
                rdata_d[speed_clk_pkg::STAT_ISR_BIT]  = in_isr_q;
                rdata_d[speed_clk_pkg::STAT_PEND_BIT] = pend_v_q;
            end else begin
                rdata_d = 32'h0;
            end
        end
        if (avs_write_in && ack_q) begin
            if (avs_address_in == speed_clk_pkg::CTRL_OFS) begin
                isr_word_d = speed_clk_pkg::speed_t'(
                             wr_word[speed_clk_pkg::SPEED_W-1:0]);
                auto_d = wr_word[speed_clk_pkg::CTRL_AUTO_BIT];
            end else if (avs_address_in == speed_clk_pkg::PLLCFG_OFS) begin
                pll_cfg_d.prediv_m1  = wr_word[speed_clk_pkg::PLL_PRE_LSB +: 4];
                pll_cfg_d.mult       = wr_word[speed_clk_pkg::PLL_MULT_LSB +: 8];
                pll_cfg_d.postdiv_m1 = wr_word[speed_clk_pkg::PLL_POST_LSB +: 4];
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            cur_q      <= speed_clk_pkg::SPEED_RESET;
            pend_q     <= speed_clk_pkg::SPEED_RESET;
            saved_q    <= speed_clk_pkg::SPEED_RESET;
            isr_word_q <= speed_clk_pkg::SPEED_RESET;
            pll_cfg_q  <= speed_clk_pkg::PLL_CFG_RESET;
            pend_v_q   <= 1'b0;
            in_isr_q   <= 1'b0;
            auto_q     <= 1'b0;
            div_cnt_q  <= 7'h00;
            core_clk_q <= 1'b0;
            ack_q      <= 1'b0;
            rdata_q    <= 32'h0;
        end else if (ce_in) begin
            cur_q      <= cur_d;
            pend_q     <= pend_d;
            saved_q    <= saved_d;
            isr_word_q <= isr_word_d;
            pll_cfg_q  <= pll_cfg_d;
            pend_v_q   <= pend_v_d;
            in_isr_q   <= in_isr_d;
            auto_q     <= auto_d;
            div_cnt_q  <= div_cnt_d;
            core_clk_q <= core_clk_d;
            ack_q      <= ack_d;
            rdata_q    <= rdata_d;
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    AST_DIV_COUNT: assert property (
        ce_in && core_clk_q |-> $past(div_cnt_q) == $past(cur_q.div_m1))
        else $error("core pulse before divisor count reached");
    AST_TIMER_UNDIV: assert property (
        ce_in && cur_q.src == speed_clk_pkg::SRC_RT
        |-> timer_clk_en_out == rt_tick)
        else $error("timer tick differs from source tick");
    AST_SRC_PLL: assert property (
        ce_in && core_tick && cur_q.src == speed_clk_pkg::SRC_PLL
        |-> pll_tick)
        else $error("core pulse without multiplier tick");
    AST_OSC_OFF: assert property (
        ce_in && cur_q.osc_off |-> !main_tick && !main_osc_en_out)
        else $error("stopped oscillator still ticking");
    AST_APPLY_AT_TICK: assert property (
        ce_in && !core_tick |=> $stable(cur_q))
        else $error("speed changed mid core cycle");
    AST_ISR_ENTER: assert property (
        ce_in && enter_acc
        |=> pend_v_q && in_isr_q && pend_q == $past(isr_word_q))
        else $error("interrupt entry speed not armed");
    AST_PLL_OFF: assert property (
        ce_in && !pll_en_out |=> !pll_locked_out ##1 !pll_tick)
        else $error("stopped multiplier still locked");
    AST_NO_RUNT: assert property (
        ce_in && core_clk_q |=> !core_clk_q || !ce_in)
        else $error("core clock high two cycles");
    AST_BUS_ANSWER: assert property (
        ce_in && avs_waitrequest_out |=> !ce_in || !avs_waitrequest_out)
        else $error("bus answer later than one cycle");

    COV_DIV_MAX: cover property (core_tick && cur_q.div_m1 == 7'h7f);
    COV_PLL_CORE: cover property (
        core_tick && cur_q.src == speed_clk_pkg::SRC_PLL);
    COV_ISR_ROUND: cover property (enter_acc ##[1:200] ret_acc);
    COV_SPEED_APPLY: cover property (speed_acc ##[1:300] core_tick);
endmodule

/* File: rtl/speed_clk_pkg.sv */
/*
 * shared types and constants of the core speed and clock control block.
 * assumes one system clock; oscillator pins are sampled, not used as clocks.
 */
package speed_clk_pkg;
    typedef enum logic [1:0] {SRC_MAIN, SRC_RT, SRC_PLL} clk_src_t;

    typedef struct packed {
        logic       osc_off;
        logic       pll_off;
        clk_src_t   src;
        logic [6:0] div_m1;
    } speed_t;

    typedef struct packed {
        logic [3:0] prediv_m1;
        logic [7:0] mult;
        logic [3:0] postdiv_m1;
    } pll_cfg_t;

    localparam int SPEED_W = 11;

    localparam logic [3:0] CTRL_OFS   = 4'h0;
    localparam logic [3:0] PLLCFG_OFS = 4'h4;
    localparam logic [3:0] STATUS_OFS = 4'h8;

    localparam int CTRL_AUTO_BIT = 16;
    localparam int PLL_PRE_LSB   = 0;
    localparam int PLL_MULT_LSB  = 8;
    localparam int PLL_POST_LSB  = 16;
    localparam int STAT_LOCK_BIT = 16;
    localparam int STAT_ISR_BIT  = 17;
    localparam int STAT_PEND_BIT = 18;

    localparam speed_t SPEED_RESET = '{osc_off: 1'b0, pll_off: 1'b0,
                                       src: SRC_MAIN, div_m1: 7'h00};
    // 4 MHz reference, x60, post /2 gives 120 MHz
    localparam pll_cfg_t PLL_CFG_RESET = '{prediv_m1: 4'h0, mult: 8'h3c,
                                           postdiv_m1: 4'h1};
    localparam int PLL_LOCK_TICKS = 64;
endpackage

/* File: rtl/osc_edge_tick.sv */
/*
 * samples an oscillator pin and gives a one-cycle tick per rising edge.
 * assumes the pin is slower than half the system clock.
 */
module osc_edge_tick (
    input  wire logic sys_clk_in,
    input  wire logic rst_in,
    input  wire logic ce_in,
    input  wire logic osc_in,
    output logic      tick_out
);
    logic sync1_q, sync2_q, prev_q;
    logic sync1_d, sync2_d, prev_d;

    always_comb begin
        sync1_d = osc_in;
        sync2_d = sync1_q;
        prev_d  = sync2_q;
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q  <= 1'b0;
        end else if (ce_in) begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            prev_q  <= prev_d;
        end
    end

    assign tick_out = ce_in & sync2_q & ~prev_q;
endmodule

/* File: rtl/pll_tick_gen.sv */
/*
 * clock multiplier with pre- and post-divider, built as a tick generator.
 * assumes the output rate stays below half the system clock: credit is
 * capped at one reference period, so a faster setting drops edges
 * instead of bursting long after a change of multiplier.
 */
module pll_tick_gen #(
    parameter int LOCK_TICKS = speed_clk_pkg::PLL_LOCK_TICKS
) (
    input  wire logic                   sys_clk_in,
    input  wire logic                   rst_in,
    input  wire logic                   ce_in,
    input  wire logic                   enable_in,
    input  wire logic                   ref_tick_in,
    input  wire speed_clk_pkg::pll_cfg_t cfg_in,
    output logic                        tick_out,
    output logic                        locked_out
);
    logic [3:0]  pre_q, pre_d, post_q, post_d;
    logic [15:0] credit_q, credit_d;
    logic [7:0]  lock_q, lock_d;
    logic        tick_q, tick_d;
    logic        pre_tick, vco_tick, locked;
    logic [16:0] sum;

    always_comb begin
        pre_tick = ref_tick_in && (pre_q == cfg_in.prediv_m1);
        // idle cycle after each edge, else the core divider drops one
        vco_tick = (credit_q != 16'h0000) && !tick_q;
        locked   = (lock_q == 8'(LOCK_TICKS));
        pre_d    = pre_q;
        post_d   = post_q;
        lock_d   = lock_q;
        tick_d   = 1'b0;
        if (ref_tick_in) begin
            pre_d = pre_tick ? 4'h0 : pre_q + 4'h1;
        end
        sum = {1'b0, credit_q} - {16'h0000, vco_tick}
              + (pre_tick ? {9'h000, cfg_in.mult} : 17'h00000);
        credit_d = (sum > {9'h000, cfg_in.mult}) ? {8'h00, cfg_in.mult}
                                                 : sum[15:0];
        if (vco_tick) begin
            if (post_q == cfg_in.postdiv_m1) begin
                post_d = 4'h0;
                tick_d = locked;
            end else begin
                post_d = post_q + 4'h1;
            end
        end
        if (pre_tick && !locked) begin
            lock_d = lock_q + 8'h01;
        end
        // stopped multiplier loses lock and all phase
        if (!enable_in) begin
            pre_d    = 4'h0;
            post_d   = 4'h0;
            credit_d = 16'h0000;
            lock_d   = 8'h00;
            tick_d   = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            pre_q    <= 4'h0;
            post_q   <= 4'h0;
            credit_q <= 16'h0000;
            lock_q   <= 8'h00;
            tick_q   <= 1'b0;
        end else if (ce_in) begin
            pre_q    <= pre_d;
            post_q   <= post_d;
            credit_q <= credit_d;
            lock_q   <= lock_d;
            tick_q   <= tick_d;
        end
    end

    assign tick_out   = ce_in & tick_q;
    assign locked_out = locked;
endmodule

/* File: dv/core_model.sv */
/*
 * behavioural processor core: speed words and interrupt pulses.
 * assumes ready is sampled at the rising edge of sys_clk_in.
 */
module core_model (
    input  wire logic             sys_clk_in,
    input  wire logic             speed_ready_in,
    output logic                  speed_valid_out,
    output speed_clk_pkg::speed_t speed_word_out,
    output logic                  irq_enter_out,
    output logic                  irq_return_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic hung = 1'b0;

    initial begin
        speed_valid_out = 1'b0;
        speed_word_out  = '0;
        irq_enter_out   = 1'b0;
        irq_return_out  = 1'b0;
    end

    // word held until taken; turned round after, so stale data never matches
    task automatic issue(input speed_clk_pkg::speed_t w, input int dly);
        int i;
        repeat (dly) @(posedge sys_clk_in);
        speed_valid_out <= 1'b1;
        speed_word_out  <= w;
        for (i = 0; i < 4000; i++) begin
            @(posedge sys_clk_in);
            if (speed_ready_in === 1'b1)
                break;
        end
        hung = hung | (i == 4000);
        speed_valid_out <= 1'b0;
        speed_word_out  <= speed_clk_pkg::speed_t'(~w);
    endtask

    // one-cycle event: routine entry when enter is high, else return
    task automatic pulse(input logic enter);
        irq_enter_out  <= enter;
        irq_return_out <= !enter;
        @(posedge sys_clk_in);
        irq_enter_out  <= 1'b0;
        irq_return_out <= 1'b0;
    endtask
endmodule

/* File: dv/test_core_speed_clock_control.sv */
/*
 * self-checking bench of the core speed and clock control block.
 * assumes oscillator pins far slower than sys_clk_in; ce_in held high.
 */
`define CHK(nm, e, g) begin \
    n_compared++; \
    if ((g) !== (e)) begin \
        n_mismatch++; \
        $display("Error %s expected %0h seen %0h", nm, e, g); \
    end \
end

module test_core_speed_clock_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MAIN_P = 6;
    localparam int RT_P   = 10;

    logic        sys_clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        ce_in = 1'b1;
    logic        main_osc_clock_in = 1'b0;
    logic        realtime_osc_clock_in = 1'b0;
    logic        speed_valid_in, irq_enter_in, irq_return_in;
    logic [3:0]  avs_address_in = 4'h0;
    logic        avs_read_in = 1'b0;
    logic        avs_write_in = 1'b0;
    logic [3:0]  avs_byteenable_in = 4'hf;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [31:0] avs_readdata_out;
    logic        avs_waitrequest_out, speed_ready_out, core_clk_out;
    logic        timer_clk_en_out, main_osc_en_out, pll_en_out;
    logic        pll_locked_out;
    int          n_mismatch = 0, n_compared = 0;
    int          mcnt = 0, rcnt = 0, since = 0, tsince = 0;
    int          last_gap = 0, timer_gap = 0;
    logic [31:0] seed = 32'h44fc1948;
    logic [31:0] rst_val [4] = '{32'h0, 32'h0001_3c00, 32'h0, 32'h0};
    speed_clk_pkg::speed_t speed_word_in;

    core_speed_clock_control DUT (
        .sys_clk_in, .rst_in, .ce_in, .main_osc_clock_in,
        .realtime_osc_clock_in, .speed_valid_in, .speed_word_in,
        .irq_enter_in, .irq_return_in, .avs_address_in, .avs_read_in,
        .avs_write_in, .avs_byteenable_in, .avs_writedata_in,
        .avs_readdata_out, .avs_waitrequest_out, .speed_ready_out,
        .core_clk_out, .timer_clk_en_out, .main_osc_en_out, .pll_en_out,
        .pll_locked_out);

    core_model core (
        .sys_clk_in, .speed_ready_in(speed_ready_out),
        .speed_valid_out(speed_valid_in), .speed_word_out(speed_word_in),
        .irq_enter_out(irq_enter_in), .irq_return_out(irq_return_in));

    always #4 sys_clk_in = !sys_clk_in;

    // a stopped oscillator holds still, as a real crystal would
    always @(posedge sys_clk_in) begin
        mcnt <= (mcnt == MAIN_P / 2 - 1) ? 0 : mcnt + 1;
        rcnt <= (rcnt == RT_P / 2 - 1) ? 0 : rcnt + 1;
        if (mcnt == MAIN_P / 2 - 1 && main_osc_en_out === 1'b1)
            main_osc_clock_in <= !main_osc_clock_in;
        if (rcnt == RT_P / 2 - 1)
            realtime_osc_clock_in <= !realtime_osc_clock_in;
        since  <= (core_clk_out === 1'b1) ? 1 : since + 1;
        tsince <= (timer_clk_en_out === 1'b1) ? 1 : tsince + 1;
        if (core_clk_out === 1'b1)
            last_gap <= since;
        if (timer_clk_en_out === 1'b1)
            timer_gap <= tsince;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic speed_clk_pkg::speed_t sw(
            input speed_clk_pkg::clk_src_t s, input int d,
            input logic [1:0] off);
        return '{osc_off: off[1], pll_off: off[0], src: s,
                 div_m1: 7'(d - 1)};
    endfunction

    function automatic int per(input speed_clk_pkg::clk_src_t s);
        return (s == speed_clk_pkg::SRC_RT) ? RT_P : MAIN_P;
    endfunction

    function automatic int exp_gap(input speed_clk_pkg::speed_t w);
        return per(w.src) * (int'(w.div_m1) + 1);
    endfunction

    task automatic summarize();
        if (n_mismatch == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic next_gap(output int g);
        int i;
        for (i = 0; i < 3000; i++) begin
            @(posedge sys_clk_in);
            if (core_clk_out === 1'b1)
                break;
        end
        if (i == 3000) begin
            n_mismatch++;
            summarize();
        end
        #1 g = last_gap;
        `CHK("no_runt", 1'b1, g > 1)
    endtask

    // two old-rate gaps and one mixed-source gap may pass first
    task automatic settle(output int g);
        repeat (4) next_gap(g);
    endtask

    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d, input logic [3:0] be,
                       output logic [31:0] q);
        int i;
        @(posedge sys_clk_in);
        avs_read_in       <= !wr;
        avs_write_in      <= wr;
        avs_address_in    <= a;
        avs_writedata_in  <= d;
        avs_byteenable_in <= be;
        for (i = 0; i < 20; i++) begin
            @(posedge sys_clk_in);
            if (avs_waitrequest_out === 1'b0)
                break;
        end
        q = avs_readdata_out;
        avs_read_in  <= 1'b0;
        avs_write_in <= 1'b0;
        if (i == 20) begin
            n_mismatch++;
            summarize();
        end
    endtask

    task automatic offer(input speed_clk_pkg::speed_t w, input int dly);
        core.issue(w, dly);
        if (core.hung) begin
            n_mismatch++;
            summarize();
        end
    endtask

    initial begin
        speed_clk_pkg::speed_t w;
        logic [31:0] q;
        int g, cnt, i;
        repeat (4) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        #1 `CHK("osc_en", 1'b1, main_osc_en_out)
        `CHK("pll_en", 1'b1, pll_en_out)
        for (i = 0; i < 4; i++) begin
            bus(1'b0, 4'(i * 4), 32'h0, 4'hf, q);
            `CHK("reg_reset", rst_val[i], q)
        end
        // status is read-only; byte lanes off stay unchanged
        bus(1'b1, speed_clk_pkg::STATUS_OFS, 32'hffff_ffff, 4'hf, q);
        bus(1'b1, speed_clk_pkg::CTRL_OFS, 32'h0001_07ff, 4'h1, q);
        bus(1'b1, 4'hc, 32'hffff_ffff, 4'hf, q);
        bus(1'b0, speed_clk_pkg::STATUS_OFS, 32'h0, 4'hf, q);
        `CHK("status_ro", 32'h0, q)
        bus(1'b0, speed_clk_pkg::CTRL_OFS, 32'h0, 4'hf, q);
        `CHK("ctrl_be", 32'h0000_00ff, q)
        // new divisor waits out the core cycle already running
        w = sw(speed_clk_pkg::SRC_MAIN, 4, 2'b00);
        offer(w, 0);
        settle(g);
        next_gap(g);
        offer(sw(speed_clk_pkg::SRC_MAIN, 1, 2'b00), 0);
        #1 `CHK("busy", 1'b0, speed_ready_out)
        bus(1'b0, speed_clk_pkg::STATUS_OFS, 32'h0, 4'hf, q);
        `CHK("pending", 1'b1, q[18])
        `CHK("old_speed", w, q[10:0])
        next_gap(g);
        `CHK("old_gap", 4 * MAIN_P, g)
        next_gap(g);
        `CHK("new_gap", MAIN_P, g)
        for (i = 0; i < 6; i++) begin
            g = (i == 0) ? 128 : (i == 1) ? 1 : int'(xs() % 128) + 1;
            w = sw((xs() % 2 == 1) ? speed_clk_pkg::SRC_RT
                                   : speed_clk_pkg::SRC_MAIN, g, 2'b00);
            offer(w, int'(xs() % 4));
            settle(g);
            `CHK("core_gap", exp_gap(w), g)
            `CHK("timer_gap", per(w.src), timer_gap)
        end
        offer(sw(speed_clk_pkg::SRC_RT, 1, 2'b11), 1);
        settle(g);
        `CHK("osc_off", 1'b0, main_osc_en_out)
        `CHK("pll_off", 1'b0, pll_en_out)
        `CHK("unlocked", 1'b0, pll_locked_out)
        offer(sw(speed_clk_pkg::SRC_RT, 1, 2'b00), 2);
        settle(g);
        `CHK("osc_on", 1'b1, main_osc_en_out)
        // multiplier at twice the main rate keeps under the core limit
        bus(1'b1, speed_clk_pkg::PLLCFG_OFS, 32'h0000_0200, 4'hf, q);
        for (i = 0; i < 3000 && pll_locked_out !== 1'b1; i++)
            @(posedge sys_clk_in);
        `CHK("locked", 1'b1, pll_locked_out)
        offer(sw(speed_clk_pkg::SRC_PLL, 1, 2'b00), 0);
        settle(g);
        cnt = 0;
        repeat (600) begin
            @(posedge sys_clk_in);
            cnt += int'(core_clk_out === 1'b1);
        end
        `CHK("pll_rate", 1'b1, cnt >= 199 && cnt <= 201)
        w = sw(speed_clk_pkg::SRC_RT, 3, 2'b00);
        bus(1'b1, speed_clk_pkg::CTRL_OFS, {15'h0, 1'b1, 5'h0, w}, 4'hf, q);
        offer(sw(speed_clk_pkg::SRC_MAIN, 2, 2'b00), 0);
        settle(g);
        core.pulse(1'b1);
        settle(g);
        `CHK("isr_gap", 3 * RT_P, g)
        bus(1'b0, speed_clk_pkg::STATUS_OFS, 32'h0, 4'hf, q);
        `CHK("in_isr", {1'b1, 6'h0, w}, q[17:0] & 18'h207ff)
        core.pulse(1'b0);
        settle(g);
        `CHK("restored_gap", 2 * MAIN_P, g)
        summarize();
    end
endmodule
